// ### bench/dip_dec_model.sv
// Purpose: decode stage model presenting instruction pairs to the pairing check
// Assumes: one register stage between request and slot outputs
// Notes: idle slot class and destination fields show the inverse of their last value
`timescale 1ns/1ps
module dip_dec_model
    import dip_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic req_v0,
    input wire dip_class_e req_c0,
    input wire logic [REG_W-1:0] req_d0,
    input wire logic req_bt,
    input wire logic [1:0] req_pl,
    input wire logic req_v1,
    input wire dip_class_e req_c1,
    input wire logic [REG_W-1:0] req_d1,
    input wire logic req_epd,
    input wire logic req_lwd,
    output logic slot0_valid,
    output dip_class_e slot0_class,
    output logic [REG_W-1:0] slot0_dst,
    output logic slot0_branch_target,
    output logic [1:0] slot0_pc_low,
    output logic slot1_valid,
    output dip_class_e slot1_class,
    output logic [REG_W-1:0] slot1_dst,
    output logic ep_wb_done,
    output logic load_wb_done
);
    // ======================================================================
    // registered decode outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slot0_valid <= 1'b0;
            slot0_class <= CLS_NOP;
            slot0_dst <= 5'h00;
            slot0_branch_target <= 1'b0;
            slot0_pc_low <= 2'h0;
            slot1_valid <= 1'b0;
            slot1_class <= CLS_NOP;
            slot1_dst <= 5'h00;
            ep_wb_done <= 1'b0;
            load_wb_done <= 1'b0;
        end else begin
            slot0_valid <= req_v0;
            slot0_class <= req_v0 ? req_c0 : dip_class_e'(~slot0_class);
            slot0_dst <= req_v0 ? req_d0 : ~slot0_dst;
            slot0_branch_target <= req_bt;
            slot0_pc_low <= req_pl;
            slot1_valid <= req_v1;
            slot1_class <= req_v1 ? req_c1 : dip_class_e'(~slot1_class);
            slot1_dst <= req_v1 ? req_d1 : ~slot1_dst;
            ep_wb_done <= req_epd;
            load_wb_done <= req_lwd;
        end
    end
endmodule

// ### bench/tb_dip_top.sv
// Purpose: self-checking bench for the dual issue pairing check
// Assumes: pairs pass through the decode model, one stage late
// Notes: reference keeps its own flag, element pointer and load state
`timescale 1ns/1ps
module tb_dip_top
    import dip_pkg::*;
;
    localparam int NB = 2;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic req_v0 = 1'b0, req_bt = 1'b0, req_v1 = 1'b0, req_epd = 1'b0, req_lwd = 1'b0;
    dip_class_e req_c0 = CLS_NOP, req_c1 = CLS_NOP;
    logic [4:0] req_d0 = 5'h00, req_d1 = 5'h00;
    logic [1:0] req_pl = 2'h0;
    logic s0v, s0bt, s1v, epd, lwd;
    dip_class_e s0c, s1c;
    logic [4:0] s0d, s1d;
    logic [1:0] s0pl;
    logic issue_r, fuse_r, pair_r, bu_r, be_r, bf_r, bl_r;
    int n_mismatch = 0, comparisons = 0, seed = 20763, nld = 0;
    logic ep_p = 1'b0, fl_p = 1'b0;
    logic [6:0] q[$];
    logic [6:0] e;
    dip_class_e cl0[14] = '{CLS_NOP, CLS_MOV, CLS_NOT, CLS_SLD, CLS_SST, CLS_SAT, CLS_LOGIC,
        CLS_TST, CLS_ADDSUB, CLS_CMP, CLS_SHIFT, CLS_MULH, CLS_EXT, CLS_OTHER};
    dip_class_e cl1[8] = '{CLS_BR, CLS_BCC, CLS_SLD, CLS_ADDSUB, CLS_SAT, CLS_MULH, CLS_MOV,
        CLS_LOAD};

    always #50 clk = ~clk;

    dip_dec_model i_dip_dec_model (.clk(clk), .reset(reset), .req_v0(req_v0), .req_c0(req_c0),
        .req_d0(req_d0), .req_bt(req_bt), .req_pl(req_pl), .req_v1(req_v1), .req_c1(req_c1),
        .req_d1(req_d1), .req_epd(req_epd), .req_lwd(req_lwd), .slot0_valid(s0v),
        .slot0_class(s0c), .slot0_dst(s0d), .slot0_branch_target(s0bt), .slot0_pc_low(s0pl),
        .slot1_valid(s1v), .slot1_class(s1c), .slot1_dst(s1d), .ep_wb_done(epd),
        .load_wb_done(lwd));
    dip_top #(.NBUF(NB)) i_dip_top (.clk(clk), .reset(reset), .slot0_valid(s0v),
        .slot0_class(s0c), .slot0_dst(s0d), .slot0_branch_target(s0bt), .slot0_pc_low(s0pl),
        .slot1_valid(s1v), .slot1_class(s1c), .slot1_dst(s1d), .ep_wb_done(epd),
        .load_wb_done(lwd), .issue_r(issue_r), .fuse_r(fuse_r), .pair_r(pair_r),
        .blk_unaligned_r(bu_r), .blk_ep_r(be_r), .blk_flag_r(bf_r), .blk_lbuf_r(bl_r));

    // ======================================================================
    // class sets
    function automatic logic in_set(dip_class_e c, logic [16:0] m);
        return m[c];
    endfunction
    localparam logic [16:0] M_FOP = 17'h00D60, M_BR = 17'h00FFF, M_BCC = 17'h0181B;
    localparam logic [16:0] M_SLD = 17'h00FE7, M_FLG = 17'h107E4;

    // ======================================================================
    // driver with reference
    task automatic send(logic v0, dip_class_e c0, logic [4:0] d0, logic bt, logic [1:0] pl,
        logic v1, dip_class_e c1, logic [4:0] d1, logic ed, logic ld, logic bc);
        logic un, fu, pa, okv, eps;
        int n;
        un = bt && pl != 2'h0;
        okv = v0 && v1 && !un;
        fu = okv && c0 == CLS_MOV && in_set(c1, M_FOP) && d0 == d1 && d0 != 5'h00;
        pa = okv && !fu && ((c1 == CLS_BR && in_set(c0, M_BR))
            || (c1 == CLS_BCC && in_set(c0, M_BCC) && !fl_p)
            || (c1 == CLS_SLD && in_set(c0, M_SLD) && !ep_p && nld < NB
                && !(c0 == CLS_MOV && d0 == 5'h1E)));
        if (v0) begin
            q.push_back({bc, fu, pa, v0 && v1 && un,
                okv && c1 == CLS_SLD && (ep_p || (c0 == CLS_MOV && d0 == 5'h1E)),
                okv && c1 == CLS_BCC && (fl_p || in_set(c0, M_FLG)),
                okv && c1 == CLS_SLD && nld == NB});
            fl_p = (fu || pa) ? in_set(c1, M_FLG) : in_set(c0, M_FLG);
        end
        eps = v0 && ((c0 == CLS_MOV && d0 == 5'h1E) || (fu && d1 == 5'h1E));
        ep_p = eps ? 1'b1 : (ed ? 1'b0 : ep_p);
        n = nld + int'(v0 && (c0 == CLS_SLD || c0 == CLS_LOAD)) + int'(pa && c1 == CLS_SLD);
        n = n - int'(ld);
        nld = n < 0 ? 0 : (n > NB ? NB : n);
        req_v0 <= v0;
        req_c0 <= c0;
        req_d0 <= d0;
        req_bt <= bt;
        req_pl <= pl;
        req_v1 <= v1;
        req_c1 <= c1;
        req_d1 <= d1;
        req_epd <= ed;
        req_lwd <= ld;
        @(posedge clk);
    endtask

    task automatic pr(dip_class_e c0, logic [4:0] d0, dip_class_e c1, logic [4:0] d1);
        send(1'b1, c0, d0, 1'b0, 2'h0, 1'b1, c1, d1, 1'b0, 1'b0, 1'b1);
    endtask

    task automatic clean();
        send(1'b1, CLS_NOP, 5'h00, 1'b0, 2'h0, 1'b0, CLS_NOP, 5'h00, 1'b1, 1'b1, 1'b0);
        send(1'b1, CLS_NOP, 5'h00, 1'b0, 2'h0, 1'b0, CLS_NOP, 5'h00, 1'b1, 1'b1, 1'b0);
    endtask

    // ======================================================================
    // monitor and compares
    task automatic cmp(string what, logic [3:0] x, logic [3:0] g);
        comparisons++;
        if (x !== g) begin
            n_mismatch++;
            $display("unexpected %s at %0t: expected %h got %h", what, $time, x, g);
        end
    endtask

    always @(negedge clk) begin
        if (issue_r === 1'b1) begin
            if (q.size() == 0) begin
                cmp("issue", 4'h0, 4'h1);
            end else begin
                e = q.pop_front();
                cmp("fuse pair", {2'h0, e[5:4]}, {2'h0, fuse_r, pair_r});
                if (e[6]) cmp("block", e[3:0], {bu_r, be_r, bf_r, bl_r});
            end
        end
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ======================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        pr(CLS_MOV, 5'h05, CLS_ADDSUB, 5'h05);
        pr(CLS_MOV, 5'h00, CLS_SAT, 5'h00);
        pr(CLS_MOV, 5'h05, CLS_SHIFT, 5'h06);
        pr(CLS_ADDSUB, 5'h05, CLS_MOV, 5'h05);
        for (int i = 0; i < 14; i++) begin
            clean();
            pr(cl0[i], 5'h05, CLS_BR, 5'h00);
            clean();
            pr(cl0[i], 5'h05, CLS_BCC, 5'h00);
            clean();
            pr(cl0[i], 5'h05, CLS_SLD, 5'h07);
            pr(CLS_NOP, 5'h00, cl1[i % 8], 5'h05);
        end
        clean();
        send(1'b1, CLS_MOV, 5'h05, 1'b1, 2'h2, 1'b1, CLS_ADDSUB, 5'h05, 1'b0, 1'b0, 1'b1);
        pr(CLS_MOV, 5'h1E, CLS_SLD, 5'h07);
        pr(CLS_NOP, 5'h00, CLS_SLD, 5'h07);
        clean();
        pr(CLS_CMP, 5'h00, CLS_BR, 5'h00);
        pr(CLS_NOP, 5'h00, CLS_BCC, 5'h00);
        pr(CLS_CMP, 5'h00, CLS_MOV, 5'h00);
        pr(CLS_NOP, 5'h00, CLS_BCC, 5'h00);
        clean();
        pr(CLS_LOAD, 5'h05, CLS_MOV, 5'h06);
        pr(CLS_LOAD, 5'h06, CLS_MOV, 5'h07);
        pr(CLS_NOP, 5'h00, CLS_SLD, 5'h07);
        send(1'b1, CLS_NOP, 5'h00, 1'b0, 2'h0, 1'b1, CLS_SLD, 5'h07, 1'b0, 1'b1, 1'b1);
        pr(CLS_NOP, 5'h00, CLS_SLD, 5'h07);
        for (int i = 0; i < 800; i++) begin
            automatic dip_class_e a = cl0[{$random(seed)} % 14];
            automatic dip_class_e b = cl1[{$random(seed)} % 8];
            automatic logic [4:0] da = (a == CLS_MOV && $random(seed) % 3 == 0) ? 5'h1E
                : 5'h05 * 5'({$random(seed)} % 2);
            automatic logic [4:0] db = (b == CLS_ADDSUB) ? da : 5'h05;
            send({$random(seed)} % 8 != 0, a, da, 1'($random(seed)), 2'($random(seed)),
                {$random(seed)} % 8 != 0, b, db, 1'($random(seed)), 1'($random(seed)),
                1'b1);
        end
        send(1'b0, CLS_NOP, 5'h00, 1'b0, 2'h0, 1'b0, CLS_NOP, 5'h00, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 20 && q.size() != 0; i++) @(posedge clk);
        if (q.size() != 0) cmp("drain", 4'h0, 4'h1);
        end_sim();
    end
endmodule

// ### hdl/dip_classify.sv
// Purpose: maps an instruction class to its pairing capabilities
// Assumes: class code comes straight from decode
// Notes: purely combinational
`timescale 1ns/1ps
module dip_classify
    import dip_pkg::*;
(
    input wire dip_class_e cls,
    output dip_caps_s caps
);
    // ======================================================================
    // capability table
    always_comb begin
        caps = '0;
        case (cls)
            CLS_NOP: begin
                caps.br_pre = 1'b1;
                caps.bcc_pre = 1'b1;
                caps.sld_pre = 1'b1;
            end
            CLS_MOV, CLS_MULH: begin
                caps.fuse_ok = (cls == CLS_MULH);
                caps.br_pre = 1'b1;
                caps.bcc_pre = 1'b1;
                caps.sld_pre = 1'b1;
                caps.wr_dst = 1'b1;
            end
            CLS_NOT: begin
                caps.br_pre = 1'b1;
                caps.sld_pre = 1'b1;
                caps.wr_flags = 1'b1;
                caps.wr_dst = 1'b1;
            end
            CLS_SLD: begin
                caps.br_pre = 1'b1;
                caps.bcc_pre = 1'b1;
                caps.wr_dst = 1'b1;
                caps.is_load = 1'b1;
            end
            CLS_SST: begin
                caps.br_pre = 1'b1;
                caps.bcc_pre = 1'b1;
            end
            CLS_SAT, CLS_LOGIC, CLS_ADDSUB, CLS_SHIFT: begin
                caps.fuse_ok = 1'b1;
                caps.br_pre = 1'b1;
                caps.sld_pre = 1'b1;
                caps.wr_flags = 1'b1;
                caps.wr_dst = 1'b1;
            end
            CLS_TST, CLS_CMP: begin
                caps.br_pre = 1'b1;
                caps.sld_pre = 1'b1;
                caps.wr_flags = 1'b1;
            end
            CLS_EXT: begin
                caps.bcc_pre = 1'b1;
                caps.wr_dst = 1'b1;
            end
            CLS_LOAD: begin
                caps.wr_dst = 1'b1;
                caps.is_load = 1'b1;
            end
            CLS_OTHER: begin
                caps.wr_flags = 1'b1;
                caps.wr_dst = 1'b1;
            end
            default: begin
                caps = '0;
            end
        endcase
    end
endmodule

// ### hdl/dip_haz_if.sv
// Purpose: carries issue events and hazard status between top and tracker
// Assumes: single core clock
// Notes: ctl drives issue facts, hz answers with hazard levels
`timescale 1ns/1ps
interface dip_haz_if;
    logic issue;
    logic last_wr_flags;
    logic wr_ep;
    logic [1:0] n_loads;
    logic ep_pend;
    logic flag_prev;
    logic loads_full;

    modport ctl (output issue, output last_wr_flags, output wr_ep, output n_loads,
        input ep_pend, input flag_prev, input loads_full);
    modport hz (input issue, input last_wr_flags, input wr_ep, input n_loads,
        output ep_pend, output flag_prev, output loads_full);
endinterface

// ### hdl/dip_hazard.sv
// Purpose: tracks element pointer writeback, flag history and load buffers
// Assumes: at most one load writeback completes per cycle
// Notes: a set in the same cycle as its clear wins
`timescale 1ns/1ps
module dip_hazard
    import dip_pkg::*;
#(
    parameter int NBUF = LOAD_BUF_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ep_wb_done,
    input wire logic load_wb_done,
    dip_haz_if.hz hif
);
    localparam int CW = $clog2(NBUF + 1);
    localparam logic [CW-1:0] NBUF_C = CW'(NBUF);

    typedef struct packed {
        logic ep_pend;
        logic flag_prev;
        logic [CW-1:0] loads;
    } dip_hz_s;

    dip_hz_s st_r;
    dip_hz_s st_nxt;
    logic [CW:0] sum;

    // ======================================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        sum = {1'b0, st_r.loads} + (CW+1)'(hif.n_loads);
        if (load_wb_done && sum != '0) begin
            sum = sum - (CW+1)'(1);
        end
        st_nxt.loads = (sum > {1'b0, NBUF_C}) ? NBUF_C : sum[CW-1:0];
        if (ep_wb_done) begin
            st_nxt.ep_pend = 1'b0;
        end
        if (hif.issue && hif.wr_ep) begin
            st_nxt.ep_pend = 1'b1;
        end
        if (hif.issue) begin
            st_nxt.flag_prev = hif.last_wr_flags;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '{ep_pend: EP_PEND_RST, flag_prev: FLAG_PREV_RST, loads: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hif.ep_pend = st_r.ep_pend;
    assign hif.flag_prev = st_r.flag_prev;
    assign hif.loads_full = (st_r.loads == NBUF_C);

    // ======================================================================
    // checks
    property p_loads_bound;
        @(posedge clk) disable iff (reset) st_r.loads <= NBUF_C;
    endproperty
    a_loads_bound: assert property (p_loads_bound) else $error("load buffer count over limit");

    property p_ep_set;
        @(posedge clk) disable iff (reset) (hif.issue && hif.wr_ep) |=> st_r.ep_pend;
    endproperty
    a_ep_set: assert property (p_ep_set) else $error("pointer write not tracked");
endmodule

// ### hdl/dip_pkg.sv
// Purpose: shared constants and types for the dual issue pairing check
// Assumes: decode delivers one instruction class code per slot
// Notes: register numbers are 5-bit architectural indices
//
// Functional notes
// - fuse move with next arithmetic op when both target same non-zero register
// - fusion only when the move comes first in program order
// - unconditional branch pairs after nop, move, not, ALU, shift, mulh, short memory ops
// - conditional branch pairs only after nop, move, short memory, mulh, extensions
// - short load pairs after nop, move, not, ALU ops, shift or mulh
// - second slot of a parallel pair is only a branch or short load
// - no pairing or fusion when first instruction is an unaligned branch target
// - no short load pairing while element pointer writeback is outstanding
// - no conditional branch pairing when either of two predecessors may set flags
// - two load buffers; no short load pairing while both await writeback
package dip_pkg;

    // ======================================================================
    // register numbers and counts
    localparam int REG_W = 5;
    localparam logic [REG_W-1:0] ZERO_REGISTER = 5'h00;
    localparam logic [REG_W-1:0] ELEMENT_POINTER_REG = 5'h1E;
    localparam int LOAD_BUF_COUNT = 2;
    localparam logic [1:0] WORD_ALIGNED_LOW = 2'h0;

    // ======================================================================
    // reset values
    localparam logic EP_PEND_RST = 1'b0;
    localparam logic FLAG_PREV_RST = 1'b0;

    // ======================================================================
    // instruction classes from decode
    typedef enum logic [4:0] {
        CLS_NOP = 5'h00,
        CLS_MOV = 5'h01,
        CLS_NOT = 5'h02,
        CLS_SLD = 5'h03,
        CLS_SST = 5'h04,
        CLS_SAT = 5'h05,
        CLS_LOGIC = 5'h06,
        CLS_TST = 5'h07,
        CLS_ADDSUB = 5'h08,
        CLS_CMP = 5'h09,
        CLS_SHIFT = 5'h0A,
        CLS_MULH = 5'h0B,
        CLS_EXT = 5'h0C,
        CLS_BR = 5'h0D,
        CLS_BCC = 5'h0E,
        CLS_LOAD = 5'h0F,
        CLS_OTHER = 5'h10
    } dip_class_e;

    // ======================================================================
    // per-class capabilities
    typedef struct packed {
        logic fuse_ok;
        logic br_pre;
        logic bcc_pre;
        logic sld_pre;
        logic wr_flags;
        logic wr_dst;
        logic is_load;
    } dip_caps_s;

endpackage

// ### hdl/dip_top.sv
// Purpose: decides fusion and parallel issue for two decoded instructions
// Assumes: decode, execute and writeback share clk; slot0 is older
// Notes: slot0 issues whenever valid; slot1 rides along only when allowed
`timescale 1ns/1ps
module dip_top
    import dip_pkg::*;
#(
    parameter int NBUF = LOAD_BUF_COUNT
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic slot0_valid,
    input wire dip_class_e slot0_class,
    input wire logic [REG_W-1:0] slot0_dst,
    input wire logic slot0_branch_target,
    input wire logic [1:0] slot0_pc_low,
    input wire logic slot1_valid,
    input wire dip_class_e slot1_class,
    input wire logic [REG_W-1:0] slot1_dst,
    input wire logic ep_wb_done,
    input wire logic load_wb_done,
    output logic issue_r,
    output logic fuse_r,
    output logic pair_r,
    output logic blk_unaligned_r,
    output logic blk_ep_r,
    output logic blk_flag_r,
    output logic blk_lbuf_r
);
    // ======================================================================
    // state
    typedef struct packed {
        logic issue;
        logic fuse;
        logic pair;
        logic blk_unaligned;
        logic blk_ep;
        logic blk_flag;
        logic blk_lbuf;
    } dip_st_s;

    dip_st_s st_r;
    dip_st_s st_nxt;
    dip_caps_s c0;
    dip_caps_s c1;
    logic unal;
    logic both;
    logic is_br;
    logic is_bcc;
    logic is_sld;
    logic s0_wr_ep;
    logic s1_wr_ep;
    logic ep_blk;
    logic flag_blk;
    logic lb_blk;
    logic fuse_c;
    logic pair_c;
    logic take1;

    dip_haz_if hif ();

    // ======================================================================
    // submodules
    dip_classify u_cls0 (
        .cls(slot0_class),
        .caps(c0)
    );

    dip_classify u_cls1 (
        .cls(slot1_class),
        .caps(c1)
    );

    dip_hazard #(
        .NBUF(NBUF)
    ) u_haz (
        .clk(clk),
        .reset(reset),
        .ep_wb_done(ep_wb_done),
        .load_wb_done(load_wb_done),
        .hif(hif)
    );

    // ======================================================================
    // pairing decision
    always_comb begin
        unal = slot0_branch_target && (slot0_pc_low != WORD_ALIGNED_LOW);
        both = slot0_valid && slot1_valid && !unal;
        is_br = (slot1_class == CLS_BR);
        is_bcc = (slot1_class == CLS_BCC);
        is_sld = (slot1_class == CLS_SLD);
        s0_wr_ep = c0.wr_dst && (slot0_dst == ELEMENT_POINTER_REG);
        s1_wr_ep = c1.wr_dst && (slot1_dst == ELEMENT_POINTER_REG);
        ep_blk = is_sld && (hif.ep_pend || s0_wr_ep);
        flag_blk = is_bcc && (hif.flag_prev || c0.wr_flags);
        lb_blk = is_sld && hif.loads_full;
        fuse_c = both && (slot0_class == CLS_MOV) && c1.fuse_ok
            && (slot0_dst == slot1_dst) && (slot1_dst != ZERO_REGISTER);
        pair_c = 1'b0;
        if (both && !fuse_c) begin
            if (is_br) begin
                pair_c = c0.br_pre;
            end else if (is_bcc) begin
                pair_c = c0.bcc_pre && !flag_blk;
            end else if (is_sld) begin
                pair_c = c0.sld_pre && !ep_blk && !lb_blk;
            end else begin
                pair_c = 1'b0;
            end
        end
        take1 = fuse_c || pair_c;
    end

    // ======================================================================
    // hazard tracker feed; issue order is unchanged, only timing
    always_comb begin
        hif.issue = slot0_valid;
        hif.wr_ep = s0_wr_ep || (take1 && s1_wr_ep);
        hif.last_wr_flags = take1 ? c1.wr_flags : c0.wr_flags;
        hif.n_loads = {1'b0, slot0_valid && c0.is_load} + {1'b0, pair_c && is_sld};
    end

    always_comb begin
        st_nxt.issue = slot0_valid;
        st_nxt.fuse = fuse_c;
        st_nxt.pair = pair_c;
        st_nxt.blk_unaligned = slot0_valid && slot1_valid && unal;
        st_nxt.blk_ep = both && ep_blk;
        st_nxt.blk_flag = both && flag_blk;
        st_nxt.blk_lbuf = both && lb_blk;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign issue_r = st_r.issue;
    assign fuse_r = st_r.fuse;
    assign pair_r = st_r.pair;
    assign blk_unaligned_r = st_r.blk_unaligned;
    assign blk_ep_r = st_r.blk_ep;
    assign blk_flag_r = st_r.blk_flag;
    assign blk_lbuf_r = st_r.blk_lbuf;

    // ======================================================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_unal_pair;
        slot0_valid && slot1_valid && unal;
    endsequence

    sequence s_sld_offer;
        slot0_valid && slot1_valid && is_sld;
    endsequence

    sequence s_bcc_offer;
        slot0_valid && slot1_valid && is_bcc;
    endsequence

    property p_fuse_dst;
        fuse_r |-> ($past(slot0_dst) == $past(slot1_dst))
            && ($past(slot1_dst) != ZERO_REGISTER) && $past(c1.fuse_ok);
    endproperty
    a_fuse_dst: assert property (p_fuse_dst) else $error("fusion with bad destination");

    property p_fuse_order;
        fuse_r |-> ($past(slot0_class) == CLS_MOV) && !pair_r;
    endproperty
    a_fuse_order: assert property (p_fuse_order) else $error("fusion without leading move");

    property p_br_pair;
        (slot0_valid && slot1_valid && !unal && is_br && c0.br_pre && !fuse_c) |=> pair_r;
    endproperty
    a_br_pair: assert property (p_br_pair) else $error("branch not paired");

    property p_bcc_pre;
        (pair_r && $past(is_bcc)) |-> $past(c0.bcc_pre);
    endproperty
    a_bcc_pre: assert property (p_bcc_pre) else $error("conditional branch after flag op");

    property p_sld_pre;
        (pair_r && $past(is_sld)) |-> $past(c0.sld_pre);
    endproperty
    a_sld_pre: assert property (p_sld_pre) else $error("short load after bad class");

    property p_second_slot;
        pair_r |-> $past(is_br || is_bcc || is_sld) && issue_r;
    endproperty
    a_second_slot: assert property (p_second_slot) else $error("illegal second slot");

    property p_unaligned;
        s_unal_pair |=> !pair_r && !fuse_r && blk_unaligned_r;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("pairing at unaligned target");

    property p_ep_block;
        (s_sld_offer ##0 (hif.ep_pend || s0_wr_ep)) |=> !pair_r;
    endproperty
    a_ep_block: assert property (p_ep_block) else $error("short load paired over pointer write");

    property p_flag_block;
        (s_bcc_offer ##0 hif.flag_prev) |=> !pair_r;
    endproperty
    a_flag_block: assert property (p_flag_block) else $error("branch paired over flag hazard");

    property p_lbuf_block;
        (s_sld_offer ##0 hif.loads_full) |=> !pair_r;
    endproperty
    a_lbuf_block: assert property (p_lbuf_block) else $error("short load paired with buffers full");

    property p_issue_kept;
        slot0_valid |=> issue_r;
    endproperty
    a_issue_kept: assert property (p_issue_kept) else $error("older instruction dropped");

    sequence s_fuse_offer;
        slot0_valid && slot1_valid && !unal && (slot0_class == CLS_MOV);
    endsequence

    property p_no_slot1;
        !slot1_valid |=> !pair_r && !fuse_r;
    endproperty
    a_no_slot1: assert property (p_no_slot1) else $error("pair without second slot");

    property p_fuse_take;
        (s_fuse_offer ##0 (c1.fuse_ok && (slot0_dst == slot1_dst)
            && (slot1_dst != ZERO_REGISTER))) |=> fuse_r;
    endproperty
    a_fuse_take: assert property (p_fuse_take) else $error("fusion missed");

    property p_fuse_zero;
        (slot1_dst == ZERO_REGISTER) |=> !fuse_r;
    endproperty
    a_fuse_zero: assert property (p_fuse_zero) else $error("fusion on zero register");

    property p_fuse_late_move;
        (slot1_class == CLS_MOV) |=> !fuse_r;
    endproperty
    a_fuse_late_move: assert property (p_fuse_late_move) else $error("late move fused");

    property p_bcc_pair;
        (s_bcc_offer ##0 (!unal && c0.bcc_pre && !hif.flag_prev && !c0.wr_flags)) |=> pair_r;
    endproperty
    a_bcc_pair: assert property (p_bcc_pair) else $error("conditional branch not paired");

    property p_sld_pair;
        (s_sld_offer ##0 (!unal && c0.sld_pre && !hif.ep_pend && !s0_wr_ep
            && !hif.loads_full)) |=> pair_r;
    endproperty
    a_sld_pair: assert property (p_sld_pair) else $error("short load not paired");

    property p_bcc_own_flags;
        (s_bcc_offer ##0 (!unal && c0.wr_flags)) |=> !pair_r && blk_flag_r;
    endproperty
    a_bcc_own_flags: assert property (p_bcc_own_flags) else $error("flag hazard missed");

    property p_ep_mark;
        (s_sld_offer ##0 (!unal && hif.ep_pend)) |=> blk_ep_r;
    endproperty
    a_ep_mark: assert property (p_ep_mark) else $error("pointer block not shown");

    property p_lbuf_mark;
        (s_sld_offer ##0 (!unal && hif.loads_full)) |=> blk_lbuf_r;
    endproperty
    a_lbuf_mark: assert property (p_lbuf_mark) else $error("buffer block not shown");

    property p_blk_need_both;
        !(slot0_valid && slot1_valid) |=> !blk_unaligned_r && !blk_ep_r && !blk_flag_r
            && !blk_lbuf_r;
    endproperty
    a_blk_need_both: assert property (p_blk_need_both) else $error("block without pair");

    property p_unal_only;
        !unal |=> !blk_unaligned_r;
    endproperty
    a_unal_only: assert property (p_unal_only) else $error("false unaligned block");

    property p_idle;
        !slot0_valid |=> !issue_r && !fuse_r && !pair_r;
    endproperty
    a_idle: assert property (p_idle) else $error("issue without instruction");

    property p_ep_track;
        (slot0_valid && s0_wr_ep) |=> hif.ep_pend;
    endproperty
    a_ep_track: assert property (p_ep_track) else $error("pointer write lost");

    property p_flag_track;
        (slot0_valid && !take1 && c0.wr_flags) |=> hif.flag_prev;
    endproperty
    a_flag_track: assert property (p_flag_track) else $error("flag history lost");

    property p_br_classes;
        (pair_r && $past(is_br)) |-> $past(c0.br_pre);
    endproperty
    a_br_classes: assert property (p_br_classes) else $error("branch after bad class");

    property p_ext_no_br;
        ((slot0_class == CLS_EXT) && is_br) |=> !pair_r;
    endproperty
    a_ext_no_br: assert property (p_ext_no_br) else $error("branch paired after extension");
endmodule
